// file: arsp_bank.sv
`timescale 1ns/1ps
`default_nettype none
module arsp_bank #(
  parameter int MS_DIV = arsp_pkg::MS_CYCLES,
  parameter logic [15:0] TYPE_ID = 16'h00a5,
  parameter logic [7:0] FW_VERSION = 8'h01
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cmdValid,
  input wire arsp_pkg::arsp_cmd_t cmd,
  output logic cmdReady,
  output logic rspValid,
  output arsp_pkg::arsp_rsp_t rsp,
  input wire logic shotPulse,
  input wire logic [1:0] shotInit,
  input wire logic goodShotPulse,
  input wire logic [1:0] goodInit,
  input wire logic defTripPulse,
  input wire logic [1:0] defInit,
  input wire logic seqDone,
  input wire logic [2:0] seqReclosures,
  input wire logic seqFinalTrip,
  input wire logic evtValid,
  input wire logic [3:0] evtChan,
  input wire logic [5:0] evtCode,
  input wire logic autoResetPulse,
  input wire logic indicatorSet,
  input wire logic [3:0] indicatorCode,
  input wire logic [7:0] faultCode,
  output logic recloseDisable,
  output logic logicReset,
  output logic internalFault,
  output logic [4:0] ledTest,
  output logic formatReq,
  output logic remoteOpen,
  output logic [7:0] nodeAddr,
  output logic baudSel,
  output logic [15:0] timeValue
);
  import arsp_pkg::*;

  typedef enum logic {ST_IDLE, ST_STREAM} arsp_state_t;

  arsp_state_t state;
  arsp_event_t evBuf [0:EVT_DEPTH-1];
  arsp_event_t batch [0:4];
  logic [5:0] rdPtr, wrPtr;
  logic [6:0] evCount;
  logic [2:0] batchCount, beat, take;
  logic [7:0] shotCnt [0:3];
  logic [7:0] goodCnt [0:3];
  logic [7:0] defCnt [0:3];
  logic [9:0] shotTotal, defTotal;
  logic [3:0] hist [0:HIST_DEPTH-1];
  logic [3:0] indState;
  logic [10:0] mask1;
  logic [7:0] mask2, mask3;
  logic [8:0] mask4;
  logic [6:0] shotMask [1:5];
  logic [4:0] ftMask;
  logic [5:0] dtMask;
  logic [9:0] password;
  logic autoRst, ovf;
  logic [31:0] msDiv;
  logic hit, okRange, prot, fire, wrAcc, wrV, push, dropEvt;
  logic [15:0] rdVal, d;

  assign d = cmd.data;
  assign cmdReady = (state == ST_IDLE);
  assign fire = cmdValid && cmdReady;
  // Protected writes are refused while remote setting is closed
  assign wrAcc = fire && cmd.write && hit && okRange
    && (!prot || remoteOpen);
  assign wrV = wrAcc && cmd.kind == ARSP_KIND_V;
  assign take = (evCount > 7'(BATCH_MAX)) ? BATCH_MAX
    : evCount[2:0];

  function automatic logic wv(input logic [3:0] ch, input logic [7:0] cd);
    return wrV && cmd.chan == ch && cmd.code == cd;
  endfunction

  function automatic logic [5:0] wrapAdd(input logic [5:0] p,
                                         input logic [2:0] n);
    logic [6:0] s;
    s = 7'(p) + 7'(n);
    if (s >= EVT_DEPTH_W) s = s - EVT_DEPTH_W;
    return s[5:0];
  endfunction

  function automatic logic [7:0] cnt8(input logic [7:0] cur,
      input logic clr, input logic wr, input logic [7:0] wd,
      input logic inc);
    logic [7:0] b;
    b = clr ? 8'h00 : (wr ? wd : cur);
    if (inc && b != CNT8_MAX) b = b + 8'h01;
    return b;
  endfunction

  function automatic logic [9:0] cnt10(input logic [9:0] cur,
      input logic clr, input logic inc);
    logic [9:0] b;
    b = clr ? 10'h000 : cur;
    if (inc && b != CNT10_MAX) b = b + 10'h001;
    return b;
  endfunction

  function automatic logic evtEnabled(input logic [3:0] ch,
                                      input logic [5:0] cd);
    logic en;
    en = 1'b0;
    if (ch == CH_MAIN) begin
      if (cd >= EV_G1_LO && cd < EV_G2_LO) en = mask1[4'(cd - EV_G1_LO)];
      else if (cd >= EV_G2_LO && cd < EV_G3_LO)
        en = mask2[3'(cd - EV_G2_LO)];
      else if (cd >= EV_G3_LO && cd < EV_G4_LO)
        en = mask3[3'(cd - EV_G3_LO)];
      else if (cd >= EV_G4_LO && cd <= EV_G4_HI)
        en = mask4[4'(cd - EV_G4_LO)];
    end else if (cd >= EV_G1_LO) begin
      if (ch <= CH_SHOT_LAST && cd <= EV_SHOT_HI)
        en = shotMask[ch][3'(cd - EV_G1_LO)];
      else if (ch == CH_FT && cd <= EV_FT_HI)
        en = ftMask[3'(cd - EV_G1_LO)];
      else if (ch == CH_DT && cd <= EV_DT_HI)
        en = dtMask[3'(cd - EV_G1_LO)];
    end
    return en;
  endfunction

  // Decode, range check and read mux for single-word commands
  always_comb begin
    hit = 1'b0;
    okRange = 1'b0;
    prot = 1'b0;
    rdVal = 16'h0000;
    case (cmd.kind)
      ARSP_KIND_T: begin
        hit = 1'b1;
        okRange = d <= TIME_MAX;
        rdVal = timeValue;
      end
      ARSP_KIND_C: begin
        hit = 1'b1;
        okRange = d == 16'h0000;
        rdVal = {14'h0000, ovf, autoRst};
      end
      ARSP_KIND_F: begin
        hit = !cmd.write;
        rdVal = TYPE_ID;
      end
      ARSP_KIND_L, ARSP_KIND_B: hit = !cmd.write;
      ARSP_KIND_V: begin
        if (cmd.chan == CH_REC) begin
          if (cmd.code == C_TOTAL) begin
            hit = !cmd.write;
            rdVal = 16'(shotTotal);
          end else if (cmd.code >= C_SHOT1 && cmd.code < C_GOOD1) begin
            hit = 1'b1;
            prot = 1'b1;
            okRange = d <= 16'(CNT8_MAX);
            rdVal = 16'(shotCnt[2'(cmd.code - C_SHOT1)]);
          end else if (cmd.code >= C_GOOD1 && cmd.code < C_HIST0) begin
            hit = 1'b1;
            prot = 1'b1;
            okRange = d <= 16'(CNT8_MAX);
            rdVal = 16'(goodCnt[2'(cmd.code - C_GOOD1)]);
          end
        end else if (cmd.chan == CH_MAIN) begin
          okRange = d <= 16'h0001;
          case (cmd.code)
            C_DEFTOT: begin
              hit = !cmd.write;
              rdVal = 16'(defTotal);
            end
            C_DEF1, C_DEF1 + 8'd1, C_DEF1 + 8'd2, C_DEF1 + 8'd3: begin
              hit = 1'b1;
              prot = 1'b1;
              okRange = d <= 16'(CNT8_MAX);
              rdVal = 16'(defCnt[2'(cmd.code - C_DEF1)]);
            end
            C_HIST0, C_HIST0 + 8'd1, C_HIST0 + 8'd2, C_HIST0 + 8'd3,
            C_HIST0 + 8'd4: begin
              hit = 1'b1;
              prot = 1'b1;
              okRange = d <= 16'(HIST_RECL_MAX)
                || (d >= 16'(HIST_FINAL_MIN) && d <= 16'h000f);
              rdVal = 16'(hist[3'(cmd.code - C_HIST0)]);
            end
            C_IND: begin
              hit = !cmd.write;
              rdVal = 16'(indState);
            end
            C_IND_CLR, C_ALL_CLR, C_SSUP: hit = cmd.write;
            C_AR_OFF: begin
              hit = 1'b1;
              rdVal = 16'(recloseDisable);
            end
            C_AR_RST, C_BAUD: begin
              hit = 1'b1;
              rdVal = (cmd.code == C_BAUD) ? 16'(baudSel) : 16'h0000;
            end
            C_MASK1: begin
              hit = 1'b1;
              okRange = d <= 16'h07ff;
              rdVal = 16'(mask1);
            end
            C_MASK2, C_MASK3: begin
              hit = 1'b1;
              okRange = d <= 16'h00ff;
              rdVal = (cmd.code == C_MASK2) ? 16'(mask2) : 16'(mask3);
            end
            C_MASK4: begin
              hit = 1'b1;
              okRange = d <= 16'h01ff;
              rdVal = 16'(mask4);
            end
            C_PW_OPEN: begin
              hit = cmd.write;
              okRange = d >= 16'h0001 && d == 16'(password);
            end
            C_PW_CHG: begin
              hit = cmd.write;
              prot = 1'b1;
              okRange = d <= PASS_MAX;
            end
            C_LEDT: begin
              hit = cmd.write;
              prot = 1'b1;
              okRange = d <= LEDTEST_MAX;
            end
            C_FMT: begin
              hit = cmd.write;
              prot = 1'b1;
              okRange = d == FMT_VALUE;
            end
            C_FCODE: begin
              hit = !cmd.write;
              rdVal = 16'(faultCode);
            end
            C_ADDR: begin
              hit = 1'b1;
              okRange = d >= ADDR_MIN && d <= ADDR_MAX;
              rdVal = 16'(nodeAddr);
            end
            C_VER: begin
              hit = !cmd.write;
              rdVal = 16'(FW_VERSION);
            end
            default: hit = 1'b0;
          endcase
        end else if (cmd.chan <= CH_DT && cmd.code == C_MASK1) begin
          hit = 1'b1;
          if (cmd.chan == CH_FT) begin
            okRange = d <= 16'h001f;
            rdVal = 16'(ftMask);
          end else if (cmd.chan == CH_DT) begin
            okRange = d <= 16'h003f;
            rdVal = 16'(dtMask);
          end else begin
            okRange = d <= 16'h007f;
            rdVal = 16'(shotMask[cmd.chan]);
          end
        end
      end
      default: hit = 1'b0;
    endcase
  end

  // Event intake and buffer pointers
  assign push = evtValid && evtEnabled(evtChan, evtCode);
  // A full buffer is judged before this cycle's pop, so a read that
  // frees room in the same cycle does not rescue the arriving event
  assign dropEvt = push && evCount == EVT_DEPTH_W;

  always_ff @(posedge clock) begin
    if (push && !dropEvt)
      evBuf[wrPtr] <= '{stamp: timeValue, chan: evtChan,
                        code: evtCode};
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdPtr <= 6'd0;
      wrPtr <= 6'd0;
      evCount <= 7'd0;
    end else begin
      logic lFire;
      lFire = fire && cmd.kind == ARSP_KIND_L && !cmd.write;
      if (push && !dropEvt) wrPtr <= wrapAdd(wrPtr, 3'd1);
      if (lFire) rdPtr <= wrapAdd(rdPtr, take);
      evCount <= evCount + 7'(push && !dropEvt) - (lFire ? 7'(take)
        : 7'd0);
    end
  end

  // Response sequencer; a batch is kept for replay until the next ARSP_KIND_L read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      beat <= 3'd0;
      batchCount <= 3'd0;
      rspValid <= 1'b0;
      rsp <= '0;
      for (int i = 0; i < 5; i++) batch[i] <= '0;
    end else begin
      rspValid <= 1'b0;
      if (state == ST_STREAM) begin
        rspValid <= 1'b1;
        rsp <= '{data: 16'h0000, evt: batch[beat],
                 hasEvt: batchCount != 3'd0,
                 last: beat + 3'd1 >= batchCount, err: 1'b0};
        if (beat + 3'd1 >= batchCount) state <= ST_IDLE;
        beat <= beat + 3'd1;
      end else if (fire && !cmd.write && (cmd.kind == ARSP_KIND_L
                   || cmd.kind == ARSP_KIND_B)) begin
        state <= ST_STREAM;
        beat <= 3'd0;
        if (cmd.kind == ARSP_KIND_L) begin
          batchCount <= take;
          for (int i = 0; i < 5; i++)
            batch[i] <= evBuf[wrapAdd(rdPtr, 3'(i))];
        end
      end else if (fire) begin
        rspValid <= 1'b1;
        rsp <= '{data: cmd.write ? 16'h0000 : rdVal, evt: '0,
                 hasEvt: 1'b0, last: 1'b1,
                 err: cmd.write ? !wrAcc : !hit};
      end
    end
  end

  // Status flags: a new condition wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      autoRst <= 1'b0;
      ovf <= 1'b0;
    end else begin
      if (autoResetPulse) autoRst <= 1'b1;
      else if (wrAcc && cmd.kind == ARSP_KIND_C) autoRst <= 1'b0;
      if (dropEvt) ovf <= 1'b1;
      else if (wrAcc && cmd.kind == ARSP_KIND_C) ovf <= 1'b0;
    end
  end

  // Counters; a written value still takes a same-cycle increment
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shotTotal <= 10'd0;
      defTotal <= 10'd0;
      for (int i = 0; i < 4; i++) begin
        shotCnt[i] <= 8'd0;
        goodCnt[i] <= 8'd0;
        defCnt[i] <= 8'd0;
      end
    end else begin
      logic clr;
      clr = wv(CH_MAIN, C_ALL_CLR) && d[0];
      shotTotal <= cnt10(shotTotal, clr, shotPulse);
      defTotal <= cnt10(defTotal, clr, defTripPulse);
      for (int i = 0; i < 4; i++) begin
        shotCnt[i] <= cnt8(shotCnt[i], clr, wv(CH_REC, C_SHOT1 + 8'(i)),
          d[7:0], shotPulse && shotInit == 2'(i));
        goodCnt[i] <= cnt8(goodCnt[i], clr, wv(CH_REC, C_GOOD1 + 8'(i)),
          d[7:0], goodShotPulse && goodInit == 2'(i));
        defCnt[i] <= cnt8(defCnt[i], clr, wv(CH_MAIN, C_DEF1 + 8'(i)),
          d[7:0], defTripPulse && defInit == 2'(i));
      end
    end
  end

  // Sequence history and indicators
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < HIST_DEPTH; i++) hist[i] <= 4'd0;
      indState <= 4'd0;
    end else begin
      if (seqDone) begin
        hist[0] <= ((4'(seqReclosures) > HIST_RECL_MAX) ? HIST_RECL_MAX
          : 4'(seqReclosures)) + (seqFinalTrip ? HIST_FINAL_ADD
          : 4'd0);
        for (int i = 1; i < HIST_DEPTH; i++)
          hist[i] <= hist[i-1];
      end else if (wv(CH_MAIN, C_ALL_CLR) && d[0]) begin
        for (int i = 0; i < HIST_DEPTH; i++) hist[i] <= 4'd0;
      end else begin
        for (int i = 0; i < HIST_DEPTH; i++)
          if (wv(CH_MAIN, C_HIST0 + 8'(i))) hist[i] <= d[3:0];
      end
      if (indicatorSet) indState <= indicatorCode;
      else if ((wv(CH_MAIN, C_IND_CLR) || wv(CH_MAIN, C_ALL_CLR)) && d[0])
        indState <= 4'd0;
    end
  end

  // Event masks
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mask1 <= '0;
      mask2 <= '0;
      mask3 <= '0;
      mask4 <= '0;
      ftMask <= '0;
      dtMask <= '0;
      for (int i = 1; i <= 5; i++) shotMask[i] <= '0;
    end else begin
      if (wv(CH_MAIN, C_MASK1)) mask1 <= d[10:0];
      if (wv(CH_MAIN, C_MASK2)) mask2 <= d[7:0];
      if (wv(CH_MAIN, C_MASK3)) mask3 <= d[7:0];
      if (wv(CH_MAIN, C_MASK4)) mask4 <= d[8:0];
      if (wv(CH_FT, C_MASK1)) ftMask <= d[4:0];
      if (wv(CH_DT, C_MASK1)) dtMask <= d[5:0];
      for (int i = 1; i <= 5; i++)
        if (wv(4'(i), C_MASK1)) shotMask[i] <= d[6:0];
    end
  end

  // Module control, password and communication settings
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      recloseDisable <= 1'b0;
      logicReset <= 1'b0;
      internalFault <= 1'b0;
      ledTest <= 5'd0;
      formatReq <= 1'b0;
      remoteOpen <= 1'b0;
      password <= PASS_RESET;
      nodeAddr <= ADDR_RESET;
      baudSel <= 1'b0;
    end else begin
      if (wv(CH_MAIN, C_AR_OFF)) recloseDisable <= d[0];
      logicReset <= wv(CH_MAIN, C_AR_RST) && d[0];
      if (wv(CH_MAIN, C_SSUP)) internalFault <= d[0];
      if (wv(CH_MAIN, C_LEDT)) ledTest <= d[4:0];
      formatReq <= wv(CH_MAIN, C_FMT);
      if (wv(CH_MAIN, C_PW_OPEN)) remoteOpen <= 1'b1;
      if (wv(CH_MAIN, C_PW_CHG)) begin
        // Zero closes remote setting; any other value becomes the key
        if (d == 16'h0000) remoteOpen <= 1'b0;
        else password <= d[9:0];
      end
      if (wv(CH_MAIN, C_ADDR)) nodeAddr <= d[7:0];
      if (wv(CH_MAIN, C_BAUD)) baudSel <= d[0];
    end
  end

  // Millisecond time base; a write restarts the current millisecond
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      msDiv <= 32'd0;
      timeValue <= 16'd0;
    end else if (wrAcc && cmd.kind == ARSP_KIND_T) begin
      msDiv <= 32'd0;
      timeValue <= d;
    end else if (msDiv == 32'(MS_DIV - 1)) begin
      msDiv <= 32'd0;
      timeValue <= (timeValue == TIME_MAX) ? 16'd0
        : timeValue + 16'd1;
    end else begin
      msDiv <= msDiv + 32'd1;
    end
  end
endmodule
`default_nettype wire

// file: arsp_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
module arsp_bank_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cmdValid,
  input wire arsp_pkg::arsp_cmd_t cmd,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire arsp_pkg::arsp_rsp_t rsp,
  input wire logic recloseDisable,
  input wire logic logicReset,
  input wire logic internalFault,
  input wire logic [4:0] ledTest,
  input wire logic [7:0] nodeAddr,
  input wire logic formatReq,
  input wire logic remoteOpen
);
  import arsp_pkg::*;
  logic take;
  logic wr0;
  assign take = cmdValid && cmdReady;
  assign wr0 = take && cmd.kind == ARSP_KIND_V && cmd.write && cmd.chan == 0;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  property p_stat;
    take && cmd.kind == ARSP_KIND_C && !cmd.write |=> rspValid
      && rsp.data[15:2] == 14'd0;
  endproperty
  a_stat: assert property (p_stat)
    else $error("status answer missing or wide");
  property p_batch;
    take && cmd.kind inside {ARSP_KIND_L, ARSP_KIND_B} |=> !cmdReady
      ##1 rspValid;
  endproperty
  a_batch: assert property (p_batch)
    else $error("batch start late");
  // Five beats at most, so the port is busy five cycles at most
  property p_blen;
    !cmdReady |-> ##[1:5] cmdReady;
  endproperty
  a_blen: assert property (p_blen)
    else $error("batch too long");
  property p_addr;
    wr0 && cmd.code == C_ADDR && (cmd.data < ADDR_MIN || cmd.data > ADDR_MAX)
      |=> rsp.err && $stable(nodeAddr);
  endproperty
  a_addr: assert property (p_addr)
    else $error("bad address stored");
  property p_dis;
    wr0 && cmd.code == C_AR_OFF && cmd.data <= 16'd1
      |=> recloseDisable == $past(cmd.data[0]);
  endproperty
  a_dis: assert property (p_dis)
    else $error("disable not taken");
  property p_lrst;
    wr0 && cmd.code == C_AR_RST && cmd.data == 16'd1
      |=> logicReset ##1 !logicReset;
  endproperty
  a_lrst: assert property (p_lrst)
    else $error("logic reset not one pulse");
  property p_ssup;
    wr0 && cmd.code == C_SSUP && cmd.data <= 16'd1
      |=> internalFault == $past(cmd.data[0]);
  endproperty
  a_ssup: assert property (p_ssup)
    else $error("fault output wrong");
  property p_led;
    ledTest <= 5'd28;
  endproperty
  a_led: assert property (p_led)
    else $error("led test out of range");
  // Format is protected, so only an open session may raise the pulse
  property p_fmt;
    wr0 && cmd.code == C_FMT && cmd.data == FMT_VALUE && remoteOpen
      |=> formatReq ##1 !formatReq;
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("format pulse wrong");
endmodule
bind arsp_bank arsp_bank_chk u_chk (.*);
`default_nettype wire

// file: arsp_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module arsp_bank_tb_top;
  import arsp_pkg::*;
  logic clock, arst_n, cmdValid, cmdReady, rspValid, e, ok;
  arsp_cmd_t cmd;
  arsp_rsp_t rsp;
  logic shotPulse, goodShotPulse, defTripPulse, seqDone, seqFinalTrip;
  logic evtValid, autoResetPulse, indicatorSet, recloseDisable, logicReset;
  logic internalFault, formatReq, remoteOpen, baudSel;
  logic [1:0] shotInit, goodInit, defInit;
  logic [2:0] seqReclosures, rc;
  logic [3:0] evtChan, indicatorCode;
  logic [5:0] evtCode;
  logic [7:0] faultCode, nodeAddr;
  logic [4:0] ledTest;
  logic [15:0] timeValue, q;
  logic [31:0] r;
  logic [3:0] hist[$];
  int bad_count, tests_run, seed, tot, dtot;
  int sh[4], gd[4], df[4];
  arsp_event_t ev;
  arsp_event_t exq[$], bat[$];
  // A 50000-cycle millisecond divider is still far longer than the event burst, so stamps stay fixed
  arsp_bank #(.MS_DIV(50000)) u_dut (.*);
  arsp_host u_host (.*);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input string s, input logic [15:0] x,
      input logic [15:0] g);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic chke(input arsp_event_t x, input arsp_event_t g);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch event expected %h seen %h", x, g);
    end
  endtask
  function automatic logic [3:0] histExp(input logic [2:0] n, input logic f);
    return 4'(n) + (f ? 4'd10 : 4'd0);
  endfunction
  function automatic int batchExp(input int n);
    return n < 5 ? n : 5;
  endfunction
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic go(input arsp_kind_t k, input logic w, input logic [3:0] ch,
      input logic [7:0] cd, input logic [15:0] d);
    u_host.xfer(k, w, ch, cd, d, q, e, ok);
    if (ok !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] cd, input logic [15:0] d, input logic x);
    go(ARSP_KIND_V, 1'b1, CH_MAIN, cd, d);
    chk("err", {15'd0, x}, {15'd0, e});
  endtask
  task automatic rd(input logic [3:0] ch, input logic [7:0] cd,
      input logic [15:0] x);
    go(ARSP_KIND_V, 1'b0, ch, cd, '0);
    chk("read", x, q);
  endtask
  initial begin
    seed = 32'h44db;
    arst_n = 1'b0;
    {shotPulse, shotInit, goodShotPulse, goodInit, defTripPulse, defInit} = '0;
    {seqDone, seqReclosures, seqFinalTrip, evtValid, evtChan, evtCode} = '0;
    {autoResetPulse, indicatorSet, indicatorCode} = '0;
    faultCode = 8'h3c;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    wr(C_ADDR, 16'd255, 1'b1);
    rd(CH_MAIN, C_ADDR, 16'd1);
    wr(C_ADDR, 16'd254, 1'b0);
    rd(CH_MAIN, C_ADDR, 16'd254);
    wr(C_LEDT, 16'd5, 1'b1);
    wr(C_PW_OPEN, 16'd1, 1'b0);
    chk("open", 16'd1, {15'd0, remoteOpen});
    wr(C_LEDT, 16'd29, 1'b1);
    wr(C_LEDT, 16'd28, 1'b0);
    chk("led", 16'd28, {11'd0, ledTest});
    for (int v = 1; v >= 0; v--) begin
      wr(C_AR_OFF, 16'(v), 1'b0);
      chk("dis", 16'(v), {15'd0, recloseDisable});
      wr(C_SSUP, 16'(v), 1'b0);
      chk("irf", 16'(v), {15'd0, internalFault});
    end
    wr(C_AR_RST, 16'd1, 1'b0);
    rd(CH_MAIN, C_FCODE, {8'd0, faultCode});
    wr(C_BAUD, 16'd2, 1'b1);
    wr(C_BAUD, 16'd1, 1'b0);
    chk("baud", 16'd1, {15'd0, baudSel});
    wr(C_FMT, 16'd2, 1'b0);
    @(posedge clock);
    {indicatorSet, indicatorCode} <= 5'h19;
    @(posedge clock);
    indicatorSet <= 1'b0;
    rd(CH_MAIN, C_IND, 16'd9);
    wr(C_IND_CLR, 16'd1, 1'b0);
    rd(CH_MAIN, C_IND, 16'd0);
    repeat (40) begin
      @(posedge clock);
      r = $random(seed);
      {defInit, defTripPulse, goodInit, goodShotPulse, shotInit,
        shotPulse} <= r[8:0];
      if (r[0]) sh[r[2:1]]++;
      if (r[3]) gd[r[5:4]]++;
      if (r[6]) df[r[8:7]]++;
    end
    @(posedge clock);
    {defTripPulse, goodShotPulse, shotPulse} <= '0;
    for (int i = 0; i < 4; i++) begin
      rd(CH_REC, C_SHOT1 + 8'(i), 16'(sh[i]));
      rd(CH_REC, C_GOOD1 + 8'(i), 16'(gd[i]));
      rd(CH_MAIN, C_DEF1 + 8'(i), 16'(df[i]));
      tot += sh[i];
      dtot += df[i];
    end
    rd(CH_REC, C_TOTAL, 16'(tot));
    rd(CH_MAIN, C_DEFTOT, 16'(dtot));
    repeat (7) begin
      @(posedge clock);
      r = $random(seed);
      rc = r[2:0] % 3'd6;
      {seqDone, seqFinalTrip, seqReclosures} <= {1'b1, r[3], rc};
      hist.push_front(histExp(rc, r[3]));
    end
    @(posedge clock);
    seqDone <= 1'b0;
    for (int i = 0; i < 5; i++)
      rd(CH_MAIN, C_HIST0 + 8'(i), 16'(hist[i]));
    wr(C_ALL_CLR, 16'd1, 1'b0);
    rd(CH_REC, C_TOTAL, 16'd0);
    rd(CH_MAIN, C_HIST0, 16'd0);
    wr(C_MASK1, 16'd2047, 1'b0);
    go(ARSP_KIND_T, 1'b1, CH_MAIN, 8'd0, 16'd1234);
    go(ARSP_KIND_T, 1'b0, CH_MAIN, 8'd0, 16'd0);
    chk("time", 16'd1234, q);
    repeat (62) begin
      @(posedge clock);
      r = $random(seed);
      ev = '{16'd1234, CH_MAIN, 6'(r[3:0] % 11 + 1)};
      {evtValid, evtChan, evtCode} <= {1'b1, ev.chan, ev.code};
      if (exq.size() < 60) exq.push_back(ev);
    end
    @(posedge clock);
    {evtValid, autoResetPulse} <= 2'b01;
    @(posedge clock);
    autoResetPulse <= 1'b0;
    go(ARSP_KIND_C, 1'b0, CH_MAIN, 8'd0, 16'd0);
    chk("status", 16'd3, q);
    go(ARSP_KIND_C, 1'b1, CH_MAIN, 8'd0, 16'd0);
    go(ARSP_KIND_C, 1'b0, CH_MAIN, 8'd0, 16'd0);
    chk("status", 16'd0, q);
    for (int b = 0; b < 13; b++) begin
      u_host.evq.delete();
      go(ARSP_KIND_L, 1'b0, CH_MAIN, 8'd0, 16'd0);
      bat = u_host.evq;
      chk("count", 16'(batchExp(exq.size())), 16'(bat.size()));
      foreach (bat[i]) chke(exq.pop_front(), bat[i]);
      repeat (2) begin
        u_host.evq.delete();
        go(ARSP_KIND_B, 1'b0, CH_MAIN, 8'd0, 16'd0);
        chk("again", 16'(bat.size()), 16'(u_host.evq.size()));
        foreach (bat[i]) chke(bat[i], u_host.evq[i]);
      end
    end
    summarize();
  end
endmodule
`default_nettype wire

// file: arsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module arsp_host (
  input wire logic clock,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire arsp_pkg::arsp_rsp_t rsp,
  output logic cmdValid,
  output arsp_pkg::arsp_cmd_t cmd
);
  import arsp_pkg::*;
  arsp_event_t evq[$];
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
  end
  task automatic xfer(input arsp_kind_t k, input logic w,
      input logic [3:0] ch, input logic [7:0] cd, input logic [15:0] d,
      output logic [15:0] q, output logic e, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    q = '0;
    e = 1'b1;
    @(negedge clock);
    while (cmdReady !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    cmdValid <= 1'b1;
    cmd <= '{k, w, ch, cd, d};
    @(posedge clock);
    cmdValid <= 1'b0;
    // Released lines must not keep a stale command
    cmd <= arsp_cmd_t'(~cmd);
    repeat (8) begin
      @(negedge clock);
      if (rspValid === 1'b1 && !ok) begin
        q = rsp.data;
        e = rsp.err;
        if (rsp.hasEvt === 1'b1) evq.push_back(rsp.evt);
        ok = !(k inside {ARSP_KIND_L, ARSP_KIND_B}) || rsp.last === 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: arsp_pkg.sv
package arsp_pkg;
  localparam int CLK_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int EVT_DEPTH = 60;
  localparam logic [6:0] EVT_DEPTH_W = 7'd60;
  localparam logic [2:0] BATCH_MAX = 3'd5;
  localparam int HIST_DEPTH = 5;
  localparam logic [15:0] TIME_MAX = 16'd59999;
  localparam logic [7:0] CNT8_MAX = 8'hff;
  localparam logic [9:0] CNT10_MAX = 10'd999;
  localparam logic [3:0] HIST_RECL_MAX = 4'd5;
  localparam logic [3:0] HIST_FINAL_ADD = 4'd10;
  localparam logic [3:0] HIST_FINAL_MIN = 4'd11;
  localparam logic [15:0] PASS_MAX = 16'd999;
  localparam logic [15:0] LEDTEST_MAX = 16'd28;
  localparam logic [15:0] ADDR_MIN = 16'd1;
  localparam logic [15:0] ADDR_MAX = 16'd254;
  localparam logic [15:0] FMT_VALUE = 16'd2;
  localparam logic [9:0] PASS_RESET = 10'd1;
  localparam logic [7:0] ADDR_RESET = 8'd1;
  localparam logic [1:0] STAT_AUTO_RESET = 2'd1;
  localparam logic [1:0] STAT_OVERFLOW = 2'd2;
  localparam logic [3:0] CH_MAIN = 4'd0;
  localparam logic [3:0] CH_SHOT_LAST = 4'd5;
  localparam logic [3:0] CH_FT = 4'd6;
  localparam logic [3:0] CH_DT = 4'd7;
  localparam logic [3:0] CH_REC = 4'd15;
  localparam logic [7:0] C_TOTAL = 8'd1;
  localparam logic [7:0] C_SHOT1 = 8'd2;
  localparam logic [7:0] C_DEFTOT = 8'd5;
  localparam logic [7:0] C_GOOD1 = 8'd6;
  localparam logic [7:0] C_DEF1 = 8'd6;
  localparam logic [7:0] C_HIST0 = 8'd10;
  localparam logic [7:0] C_IND = 8'd15;
  localparam logic [7:0] C_IND_CLR = 8'd101;
  localparam logic [7:0] C_ALL_CLR = 8'd102;
  localparam logic [7:0] C_AR_OFF = 8'd153;
  localparam logic [7:0] C_AR_RST = 8'd154;
  localparam logic [7:0] C_MASK1 = 8'd155;
  localparam logic [7:0] C_MASK2 = 8'd156;
  localparam logic [7:0] C_MASK3 = 8'd157;
  localparam logic [7:0] C_MASK4 = 8'd158;
  localparam logic [7:0] C_PW_OPEN = 8'd160;
  localparam logic [7:0] C_PW_CHG = 8'd161;
  localparam logic [7:0] C_SSUP = 8'd165;
  localparam logic [7:0] C_LEDT = 8'd166;
  localparam logic [7:0] C_FMT = 8'd167;
  localparam logic [7:0] C_FCODE = 8'd169;
  localparam logic [7:0] C_ADDR = 8'd200;
  localparam logic [7:0] C_BAUD = 8'd201;
  localparam logic [7:0] C_VER = 8'd205;
  localparam logic [5:0] EV_G1_LO = 6'd1;
  localparam logic [5:0] EV_G2_LO = 6'd12;
  localparam logic [5:0] EV_G3_LO = 6'd20;
  localparam logic [5:0] EV_G4_LO = 6'd28;
  localparam logic [5:0] EV_G4_HI = 6'd36;
  localparam logic [5:0] EV_SHOT_HI = 6'd7;
  localparam logic [5:0] EV_FT_HI = 6'd5;
  localparam logic [5:0] EV_DT_HI = 6'd6;
  typedef enum logic [2:0] {
    ARSP_KIND_V, ARSP_KIND_L, ARSP_KIND_B, ARSP_KIND_F, ARSP_KIND_C,
    ARSP_KIND_T
  } arsp_kind_t;
  typedef struct packed {
    logic [15:0] stamp;
    logic [3:0] chan;
    logic [5:0] code;
  } arsp_event_t;
  typedef struct packed {
    arsp_kind_t kind;
    logic write;
    logic [3:0] chan;
    logic [7:0] code;
    logic [15:0] data;
  } arsp_cmd_t;
  typedef struct packed {
    logic [15:0] data;
    arsp_event_t evt;
    logic hasEvt;
    logic last;
    logic err;
  } arsp_rsp_t;
endpackage
